// ===== verilog/adc_cfg_pkg.sv
// Register map, field layout and data path constants of the back end
`default_nettype none
package adc_cfg_pkg;

  // ==========================================================
  // Register indices and byte addresses
  localparam logic [11:0] SWAP_IDX = 12'h09b;
  localparam logic [11:0] DITHER_IDX = 12'h09d;
  localparam logic [11:0] LSB_IDX = 12'h160;
  localparam logic [31:0] SWAP_ADDR = {18'h00000, SWAP_IDX, 2'h0};
  localparam logic [31:0] DITHER_ADDR = {18'h00000, DITHER_IDX, 2'h0};
  localparam logic [31:0] LSB_ADDR = {18'h00000, LSB_IDX, 2'h0};

  // ==========================================================
  // Reset values
  localparam logic [7:0] SWAP_RESET = 8'h07;
  localparam logic [7:0] DITHER_RESET = 8'h00;
  localparam logic [7:0] LSB_RESET = 8'h00;

  // ==========================================================
  // Field positions
  localparam int DELAY_MSB = 4;
  localparam int DELAY_LSB = 0;
  localparam int DITHER_ON_BIT = 0;
  localparam int DITHER_AMP_BIT = 1;
  localparam int ROUND_ERR_BIT = 2;
  localparam int TS_EN_BIT = 0;

  // ==========================================================
  // Data path widths
  localparam int DELAY_W = 5;
  localparam int HIST_W = 31;
  localparam int CONV_W = 9;
  localparam int LINK_N = 16;
  localparam int PAD_W = LINK_N - CONV_W - 1;
  localparam int PIPE_DEPTH = 2;
  localparam logic [1:0] ILA_CS = 2'h0;

  // ==========================================================
  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage

`default_nettype wire

// ===== verilog/adc_swap_dither_timestamp_ctrl.sv
// Swap select delay, dither and timestamp insertion with AHB-Lite registers
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module adc_swap_dither_timestamp_ctrl
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // Core data and swap control
  input wire logic [8:0] core_a_data_in,
  input wire logic [8:0] core_b_data_in,
  input wire logic swap_active_in,
  input wire logic swap_sel_in,
  input wire logic timestamp_in,
  // Encoder side
  output logic swap_mux_sel_out,
  output logic [15:0] sample_out,
  output logic [1:0] ila_control_bits_out,
  // Analog dither and timestamp insertion controls
  output logic dither_on_out,
  output logic dither_amplitude_select_out,
  output logic rounding_error_select_out,
  output logic timestamp_insert_enable_out
);

  // ==========================================================
  // Bus address phase capture
  logic wr_act_reg;
  logic [31:0] wr_addr_reg;
  logic addr_phase;
  logic [7:0] swap_reg;
  logic [7:0] swap_next;
  logic [7:0] dither_reg;
  logic [7:0] dither_next;
  logic [7:0] lsb_reg;
  logic [7:0] lsb_next;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_next;

  assign addr_phase = hsel_in && hready_in && htrans_in[1];
  assign hreadyout_out = 1'b1;
  assign hresp_out = adc_cfg_pkg::HRESP_OKAY;
  assign hrdata_out = hrdata_reg;

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      wr_act_reg <= 1'b0;
      wr_addr_reg <= 32'h00000000;
    end
    else if (hready_in)
    begin
      wr_act_reg <= addr_phase && hwrite_in;
      wr_addr_reg <= haddr_in;
    end
  end

  // ==========================================================
  // Register next values in the data phase
  always_comb
  begin
    swap_next = swap_reg;
    dither_next = dither_reg;
    lsb_next = lsb_reg;
    if (wr_act_reg)
    begin
      if (wr_addr_reg == adc_cfg_pkg::SWAP_ADDR)
      begin
        swap_next = hwdata_in[7:0];
      end
      else if (wr_addr_reg == adc_cfg_pkg::DITHER_ADDR)
      begin
        dither_next = hwdata_in[7:0];
      end
      else if (wr_addr_reg == adc_cfg_pkg::LSB_ADDR)
      begin
        lsb_next = hwdata_in[7:0];
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      swap_reg <= adc_cfg_pkg::SWAP_RESET;
      dither_reg <= adc_cfg_pkg::DITHER_RESET;
      lsb_reg <= adc_cfg_pkg::LSB_RESET;
    end
    else
    begin
      swap_reg <= swap_next;
      dither_reg <= dither_next;
      lsb_reg <= lsb_next;
    end
  end

  // ==========================================================
  // Read data, forwarded from a write in the same edge
  always_comb
  begin
    rd_next = 32'h00000000;
    if (haddr_in == adc_cfg_pkg::SWAP_ADDR)
    begin
      rd_next = {24'h000000, swap_next};
    end
    else if (haddr_in == adc_cfg_pkg::DITHER_ADDR)
    begin
      rd_next = {24'h000000, dither_next};
    end
    else if (haddr_in == adc_cfg_pkg::LSB_ADDR)
    begin
      rd_next = {24'h000000, lsb_next};
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      hrdata_reg <= 32'h00000000;
    end
    else if (addr_phase && !hwrite_in)
    begin
      hrdata_reg <= rd_next;
    end
  end

  // ==========================================================
  // Dither, timestamp enable and control bit outputs
  assign dither_on_out = dither_reg[adc_cfg_pkg::DITHER_ON_BIT];
  assign dither_amplitude_select_out =
    dither_reg[adc_cfg_pkg::DITHER_AMP_BIT];
  assign rounding_error_select_out =
    dither_reg[adc_cfg_pkg::ROUND_ERR_BIT];
  assign timestamp_insert_enable_out = lsb_reg[adc_cfg_pkg::TS_EN_BIT];
  assign ila_control_bits_out = adc_cfg_pkg::ILA_CS;

  // ==========================================================
  // Swap select delay line
  logic [30:0] sel_hist_reg;
  logic [4:0] dly;
  logic sel_tap;
  logic eff_sel;

  assign dly = swap_reg[adc_cfg_pkg::DELAY_MSB:adc_cfg_pkg::DELAY_LSB];

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      sel_hist_reg <= 31'h0;
    end
    else
    begin
      sel_hist_reg <= {sel_hist_reg[29:0], swap_sel_in};
    end
  end

  always_comb
  begin
    if (dly == 5'h00)
    begin
      sel_tap = swap_sel_in;
    end
    else
    begin
      sel_tap = sel_hist_reg[dly - 5'h01];
    end
  end

  assign eff_sel = swap_active_in ? sel_tap : swap_sel_in;

  // ==========================================================
  // Sample pipeline with matched timestamp path
  logic sel_reg;
  logic [8:0] conv_reg;
  logic ts_reg;
  logic [15:0] sample_reg;

  assign swap_mux_sel_out = sel_reg;
  assign sample_out = sample_reg;

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      sel_reg <= 1'b0;
      conv_reg <= 9'h000;
      ts_reg <= 1'b0;
    end
    else
    begin
      sel_reg <= eff_sel;
      conv_reg <= eff_sel ? core_b_data_in : core_a_data_in;
      ts_reg <= timestamp_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      sample_reg <= 16'h0000;
    end
    else
    begin
      sample_reg <= {conv_reg, 6'h00,
        timestamp_insert_enable_out && ts_reg};
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_dither_wr;
    wr_act_reg && wr_addr_reg == adc_cfg_pkg::DITHER_ADDR;
  endsequence

  sequence s_lsb_wr;
    wr_act_reg && wr_addr_reg == adc_cfg_pkg::LSB_ADDR;
  endsequence

  property p_delay_reset;
    disable iff (1'b0)
    !nrst_in |=> swap_reg == adc_cfg_pkg::SWAP_RESET;
  endproperty
  a_delay_reset: assert property (p_delay_reset)
    else $error("Swap delay reset value wrong");

  property p_delay_seven;
    swap_active_in && dly == 5'h07 |=>
      swap_mux_sel_out == $past(swap_sel_in, 8);
  endproperty
  a_delay_seven: assert property (p_delay_seven)
    else $error("Delayed swap select mismatch");

  property p_no_swap;
    !swap_active_in |=> swap_mux_sel_out == $past(swap_sel_in);
  endproperty
  a_no_swap: assert property (p_no_swap)
    else $error("Select delayed outside a swap");

  property p_dither_on;
    s_dither_wr |=> dither_on_out == $past(hwdata_in[0]);
  endproperty
  a_dither_on: assert property (p_dither_on)
    else $error("Dither enable not taken");

  property p_dither_amp;
    s_dither_wr |=> dither_amplitude_select_out == $past(hwdata_in[1]);
  endproperty
  a_dither_amp: assert property (p_dither_amp)
    else $error("Dither amplitude not taken");

  property p_round_err;
    s_dither_wr |=> rounding_error_select_out == $past(hwdata_in[2]);
  endproperty
  a_round_err: assert property (p_round_err)
    else $error("Rounding error choice not taken");

  property p_ts_enable;
    s_lsb_wr ##1 !wr_act_reg [*2] |->
      timestamp_insert_enable_out == $past(hwdata_in[0], 2);
  endproperty
  a_ts_enable: assert property (p_ts_enable)
    else $error("Timestamp enable not taken");

  property p_ts_latency;
    ##2 1'b1 |-> sample_out[0] ==
      ($past(timestamp_insert_enable_out) && $past(timestamp_in, 2));
  endproperty
  a_ts_latency: assert property (p_ts_latency)
    else $error("Timestamp latency mismatch");

  property p_conv_kept;
    ##2 1'b1 |-> sample_out[15:7] == ($past(eff_sel, 2) ?
      $past(core_b_data_in, 2) : $past(core_a_data_in, 2));
  endproperty
  a_conv_kept: assert property (p_conv_kept)
    else $error("Converter bits overwritten");

  property p_ila_cs;
    ila_control_bits_out == 2'h0;
  endproperty
  a_ila_cs: assert property (p_ila_cs)
    else $error("Control bits advertised");

endmodule

`default_nettype wire

// ===== testbench/link_rx_model.sv
// Receiver side model that unpacks link samples
`timescale 1ns/1ps
`default_nettype none
module link_rx_model
(
  // Link side
  input wire logic [15:0] sample_in,
  input wire logic [1:0] ila_cs_in,
  // Unpacked fields
  output logic [8:0] conv_out,
  output logic ctl_out,
  output logic ctl_adv_out
);
  // ==========================================================
  // Field split
  assign conv_out = sample_in[15:7];
  assign ctl_out = sample_in[0];
  assign ctl_adv_out = |ila_cs_in;
endmodule
`default_nettype wire

// ===== testbench/tb_adc_swap_dither_timestamp_ctrl.sv
// Self-checking bench for the back end register bank
`timescale 1ns/1ps
`default_nettype none
module tb_adc_swap_dither_timestamp_ctrl;
  logic clk_in = 0, nrst_in = 0, hsel_in = 0, hwrite_in = 0, hrdy, hresp;
  logic [31:0] haddr_in = 0, hwdata_in = 0, hrdata, rd;
  logic [1:0] htrans_in = 0, ila;
  logic [8:0] core_a = 0, core_b = 0, rx_conv;
  logic sw_act = 0, sw_sel = 0, ts = 0, sel_o, d_on, d_amp, r_err, ts_en;
  logic rx_ctl, rx_adv;
  logic [15:0] samp;
  int bad_count = 0, checks = 0, cyc = 0;

  // ==========================================================
  // Design and receiver
  adc_swap_dither_timestamp_ctrl dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
    .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(hresp),
    .hrdata_out(hrdata), .core_a_data_in(core_a), .core_b_data_in(core_b),
    .swap_active_in(sw_act), .swap_sel_in(sw_sel), .timestamp_in(ts),
    .swap_mux_sel_out(sel_o), .sample_out(samp),
    .ila_control_bits_out(ila), .dither_on_out(d_on),
    .dither_amplitude_select_out(d_amp),
    .rounding_error_select_out(r_err),
    .timestamp_insert_enable_out(ts_en));
  link_rx_model rx_u (.sample_in(samp), .ila_cs_in(ila),
    .conv_out(rx_conv), .ctl_out(rx_ctl), .ctl_adv_out(rx_adv));

  initial forever #12.5 clk_in = ~clk_in;

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    hsel_in <= 1'b1;
    haddr_in <= a;
    htrans_in <= adc_cfg_pkg::HTRANS_NONSEQ;
    hwrite_in <= w;
    @(posedge clk_in);
    while (hrdy !== 1'b1) @(posedge clk_in);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    @(posedge clk_in);
    while (hrdy !== 1'b1) @(posedge clk_in);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic at(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    bus(0, adc_cfg_pkg::SWAP_ADDR, 0);
    chk(rd, 32'h07);
    bus(0, adc_cfg_pkg::DITHER_ADDR, 0);
    chk(rd, 32'h0);
    bus(0, adc_cfg_pkg::LSB_ADDR, 0);
    chk(rd, 32'h0);
    bus(0, 32'h0, 0);
    chk(rd, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      bus(1, adc_cfg_pkg::DITHER_ADDR, i);
      at(1);
      chk({r_err, d_amp, d_on}, i);
      @(posedge clk_in);
    end
    bus(1, adc_cfg_pkg::SWAP_ADDR, 32'h1f);
    bus(0, adc_cfg_pkg::SWAP_ADDR, 0);
    chk(rd, 32'h1f);
    $display("register test done");
  endtask

  task automatic t_stamp;
    bus(1, adc_cfg_pkg::LSB_ADDR, 1);
    core_a <= 9'h1a5;
    core_b <= 9'h05a;
    ts <= 1'b1;
    at(2);
    chk({ts_en, rx_ctl, rx_adv}, 3'h6);
    chk(rx_conv, 9'h1a5);
    chk(samp[6:1], 6'h0);
    @(posedge clk_in);
    ts <= 1'b0;
    at(1);
    chk(rx_ctl, 1'b1);
    at(1);
    chk(rx_ctl, 1'b0);
    @(posedge clk_in);
    bus(1, adc_cfg_pkg::LSB_ADDR, 0);
    ts <= 1'b1;
    at(3);
    chk(rx_ctl, 1'b0);
    $display("timestamp test done");
  endtask

  task automatic t_swap;
    @(posedge clk_in);
    bus(1, adc_cfg_pkg::SWAP_ADDR, 3);
    sw_act <= 1'b1;
    at(6);
    @(posedge clk_in);
    sw_sel <= 1'b1;
    at(3);
    chk(sel_o, 1'b0);
    at(1);
    chk(sel_o, 1'b1);
    at(2);
    chk(rx_conv, 9'h05a);
    @(posedge clk_in);
    sw_act <= 1'b0;
    sw_sel <= 1'b0;
    at(1);
    chk(sel_o, 1'b0);
    $display("swap test done");
  endtask

  task automatic t_reset;
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    bus(0, adc_cfg_pkg::SWAP_ADDR, 0);
    chk(rd, 32'h07);
    bus(0, adc_cfg_pkg::DITHER_ADDR, 0);
    chk(rd, 32'h0);
    chk({r_err, d_amp, d_on}, 3'h0);
    chk({ts_en, rx_ctl}, 2'h0);
    sw_act <= 1'b1;
    sw_sel <= 1'b1;
    at(7);
    chk(sel_o, 1'b0);
    at(1);
    chk(sel_o, 1'b1);
    @(posedge clk_in);
    sw_act <= 1'b0;
    sw_sel <= 1'b0;
    $display("reset test done");
  endtask

  // ==========================================================
  // Run control
  task automatic final_report;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      bad_count++;
      final_report();
    end
  end

  initial
  begin
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    t_regs();
    t_stamp();
    t_swap();
    t_reset();
    final_report();
  end
endmodule
`default_nettype wire
